// [shared/sfc_pkg.sv]
package sfc_pkg;
    typedef enum logic [2:0] {
        SFC_OP_NULL   = 3'b000,
        SFC_OP_RESET  = 3'b001,
        SFC_OP_LOCK   = 3'b010,
        SFC_OP_UNLOCK = 3'b011,
        SFC_OP_WRITE  = 3'b100,
        SFC_OP_READ   = 3'b101
    } sfc_op_t;

    typedef enum logic [2:0] {
        SFC_ST_IDLE  = 3'b000,
        SFC_ST_LEAD  = 3'b001,
        SFC_ST_HIGH  = 3'b010,
        SFC_ST_LOW   = 3'b011,
        SFC_ST_TRAIL = 3'b100,
        SFC_ST_GAP   = 3'b101,
        SFC_ST_WAIT  = 3'b110
    } sfc_state_t;

    localparam logic [15:0] CMD_NULL   = 16'h0000;
    localparam logic [15:0] CMD_RESET  = 16'h0011;
    localparam logic [15:0] CMD_LOCK   = 16'h0555;
    localparam logic [15:0] CMD_UNLOCK = 16'h0655;
    localparam logic [2:0]  PFX_WRITE  = 3'h3;
    localparam logic [2:0]  PFX_READ   = 3'h5;
    localparam logic [1:0]  WRITE_GAP  = 2'h0;
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    localparam logic [15:0] POLY_ANSI  = 16'h8005;
    localparam logic [15:0] CRC_SEED   = 16'hffff;
    localparam logic [15:0] PAD16      = 16'h0000;
    localparam logic [5:0]  WLEN_SHORT = 6'h18;
    localparam logic [5:0]  WLEN_LONG  = 6'h20;
    localparam logic [5:0]  MIN_WORDS  = 6'h04;
    localparam logic [5:0]  DATA_OFS   = 6'h02;
    localparam logic [5:0]  READ_EXTRA = 6'h02;
    localparam logic [5:0]  WRITE_EXTRA = 6'h04;
    localparam logic [5:0]  ONE6       = 6'h01;
    localparam logic [10:0] ONE11      = 11'h001;
    localparam int          SCLK_HALF_CYC = 4;
    localparam int          WR_WORDS   = 8;
    localparam int          RD_WORDS   = 32;
endpackage

// [rtl/sfc_word_ram.sv]
module sfc_word_ram #(
    parameter int W  = 16,
    parameter int D  = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Registered read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem [D];
    logic [W-1:0] rd_q;

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem[rd_addr];
        end
    end

    assign rd_data = rd_q;
endmodule // sfc_word_ram

// [rtl/sfc_host.sv]
module sfc_host #(
    parameter int HALF_DIV = sfc_pkg::SCLK_HALF_CYC,
    parameter int WR_DEPTH = sfc_pkg::WR_WORDS,
    parameter int RD_DEPTH = sfc_pkg::RD_WORDS
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // Orders
    input  wire logic             cmd_valid,
    output logic                  cmd_ready,
    input  wire sfc_pkg::sfc_op_t cmd_op,
    input  wire logic [7:0]       cmd_addr,
    input  wire logic [4:0]       cmd_count,
    input  wire logic             cfg_word32,
    input  wire logic             cfg_crc_ansi,
    // Write data staging
    input  wire logic             wr_en,
    input  wire logic [2:0]       wr_idx,
    input  wire logic [15:0]      wr_data,
    // Answers
    output logic                  rsp_valid,
    output logic [23:0]           rsp_status,
    output logic [23:0]           rsp_ch_a,
    output logic [23:0]           rsp_ch_b,
    output logic                  rsp_crc_bad,
    output logic                  rsp_read_frame,
    input  wire logic [4:0]       rd_idx,
    output logic [23:0]           rd_word,
    // Device pins and synchronised ready status
    output logic                  chip_select_n,
    output logic                  sclk,
    output logic                  mosi,
    input  wire logic             miso,
    input  wire logic             data_ready_n,
    output logic                  ready_fall,
    output logic                  dev_ready
);
    import sfc_pkg::*;

    localparam int DVW = $clog2(HALF_DIV) + 1;
    localparam logic [DVW-1:0] DIV_LAST = DVW'(HALF_DIV - 1);
    localparam int RSP_MAX = HALF_DIV + 1;

    sfc_state_t  state_q, state_d;
    logic [DVW-1:0] div_q, div_d;
    logic        cs_n_q, cs_n_d, sclk_q, sclk_d, mosi_q, mosi_d;
    logic [31:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
    logic [15:0] crc_tx_q, crc_tx_d, crc_rx_q, crc_rx_d;
    logic [5:0]  bit_q, bit_d, word_q, word_d, nw_q, nw_d;
    logic [5:0]  outw_q, outw_d, rd_m_q, rd_m_d;
    sfc_op_t     op_q, op_d;
    logic [7:0]  addr_q, addr_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        w32_q, w32_d, ansi_q, ansi_d;
    logic        rd_pend_q, rd_pend_d, rdfr_q, rdfr_d;
    logic [23:0] status_q, status_d, cha_q, cha_d, chb_q, chb_d;
    logic        crc_bad_q, crc_bad_d, rsp_valid_q, rsp_valid_d;
    logic        cmd_ready_q, cmd_ready_d;
    logic [10:0] pcnt_q, pcnt_d;
    logic        miso_m_q, miso_s_q, rdy_m_q, rdy_s_q, rdy_p_q, fall_q;
    logic        tick, tx_cnt_en, rx_we;
    logic [5:0]  wlen, nxt_idx, nwr, in_w, out_w;
    logic [31:0] rx_nx;
    logic [23:0] rx_val;
    logic [15:0] nxt_word, wr_word;
    sfc_op_t     op_eff;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b,
                                             input logic ansi);
        logic [15:0] poly;
        poly = ansi ? POLY_ANSI : POLY_CCITT;
        // MSB first, result used as is
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : PAD16);
    endfunction

    function automatic logic [15:0] cmd_word(input sfc_op_t op,
                                             input logic [7:0] a,
                                             input logic [4:0] n);
        unique case (op)
            SFC_OP_RESET:  cmd_word = CMD_RESET;
            SFC_OP_LOCK:   cmd_word = CMD_LOCK;
            SFC_OP_UNLOCK: cmd_word = CMD_UNLOCK;
            SFC_OP_WRITE:  cmd_word = {PFX_WRITE, a, WRITE_GAP, n[2:0]};
            SFC_OP_READ:   cmd_word = {PFX_READ, a, n};
            default:       cmd_word = CMD_NULL;
        endcase
    endfunction

    sfc_word_ram #(.W(16), .D(WR_DEPTH), .AW(3)) u_tx_ram (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wr_en   (wr_en),
        .wr_addr (wr_idx),
        .wr_data (wr_data),
        .rd_addr (3'(word_q - ONE6)),
        .rd_data (wr_word)
    );

    sfc_word_ram #(.W(24), .D(RD_DEPTH), .AW(5)) u_rx_ram (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wr_en   (rx_we),
        .wr_addr (5'(word_q - ONE6)),
        .wr_data (rx_val),
        .rd_addr (rd_idx),
        .rd_data (rd_word)
    );

    // Pin inputs cross in through two flops each
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
            rdy_m_q  <= 1'b0;
            rdy_s_q  <= 1'b0;
            rdy_p_q  <= 1'b0;
            fall_q   <= 1'b0;
        end else begin
            miso_m_q <= miso;
            miso_s_q <= miso_m_q;
            rdy_m_q  <= data_ready_n;
            rdy_s_q  <= rdy_m_q;
            rdy_p_q  <= rdy_s_q;
            fall_q   <= rdy_p_q & ~rdy_s_q;
        end
    end

    always_comb begin
        state_d = state_q;   cs_n_d = cs_n_q;     sclk_d = sclk_q;
        mosi_d = mosi_q;     tx_sh_d = tx_sh_q;   rx_sh_d = rx_sh_q;
        crc_tx_d = crc_tx_q; crc_rx_d = crc_rx_q; bit_d = bit_q;
        word_d = word_q;     nw_d = nw_q;         outw_d = outw_q;
        rd_m_d = rd_m_q;     op_d = op_q;         addr_d = addr_q;
        cnt_d = cnt_q;       w32_d = w32_q;       ansi_d = ansi_q;
        rd_pend_d = rd_pend_q; rdfr_d = rdfr_q;   status_d = status_q;
        cha_d = cha_q;       chb_d = chb_q;       crc_bad_d = crc_bad_q;
        cmd_ready_d = cmd_ready_q; pcnt_d = pcnt_q;
        rsp_valid_d = 1'b0;
        rx_we = 1'b0;
        tick = (div_q == DIV_LAST);
        div_d = (state_q == SFC_ST_IDLE || tick) ? '0 : div_q + 1'b1;
        wlen = w32_q ? WLEN_LONG : WLEN_SHORT;
        rx_nx = {rx_sh_q[30:0], miso_s_q};
        rx_val = w32_q ? rx_nx[31:8] : rx_nx[23:0];
        nxt_idx = word_q + ONE6;
        nwr = 6'(cnt_q[2:0]) + ONE6;
        op_eff = rd_pend_q ? SFC_OP_NULL : cmd_op;
        in_w = (op_eff == SFC_OP_WRITE) ?
               6'(cmd_count[2:0]) + WRITE_EXTRA : MIN_WORDS;
        out_w = rd_pend_q ? rd_m_q + READ_EXTRA : MIN_WORDS;
        tx_cnt_en = (word_q == '0) || (op_q == SFC_OP_WRITE &&
                    word_q >= DATA_OFS && word_q < DATA_OFS + nwr);
        if (nxt_idx == ONE6) begin
            nxt_word = crc_tx_q;
        end else if (op_q == SFC_OP_WRITE && nxt_idx >= DATA_OFS &&
                     nxt_idx < DATA_OFS + nwr) begin
            nxt_word = wr_word;
        end else if (op_q == SFC_OP_WRITE && nxt_idx == DATA_OFS + nwr) begin
            nxt_word = crc_tx_q;
        end else begin
            nxt_word = PAD16;
        end
        unique case (state_q)
            SFC_ST_IDLE: begin
                if (cmd_valid && cmd_ready_q) begin
                    op_d = op_eff;
                    addr_d = cmd_addr;
                    cnt_d = cmd_count;
                    w32_d = cfg_word32;
                    ansi_d = cfg_crc_ansi;
                    rdfr_d = rd_pend_q;
                    rd_pend_d = (op_eff == SFC_OP_READ);
                    rd_m_d = 6'(cmd_count) + ONE6;
                    nw_d = (in_w > out_w) ? in_w : out_w;
                    outw_d = out_w;
                    tx_sh_d = {cmd_word(op_eff, cmd_addr, cmd_count),
                               PAD16};
                    crc_tx_d = CRC_SEED;
                    crc_rx_d = CRC_SEED;
                    word_d = '0;
                    bit_d = '0;
                    pcnt_d = '0;
                    crc_bad_d = 1'b0;
                    cs_n_d = 1'b0;
                    cmd_ready_d = 1'b0;
                    state_d = SFC_ST_LEAD;
                end
            end
            SFC_ST_LEAD, SFC_ST_LOW: begin
                if (tick) begin
                    // Launch on the rising edge
                    sclk_d = 1'b1;
                    mosi_d = tx_sh_q[31];
                    tx_sh_d = {tx_sh_q[30:0], 1'b0};
                    pcnt_d = pcnt_q + ONE11;
                    if (tx_cnt_en) begin
                        crc_tx_d = crc_step(crc_tx_q, tx_sh_q[31], ansi_q);
                    end
                    state_d = SFC_ST_HIGH;
                end
            end
            SFC_ST_HIGH: begin
                if (tick) begin
                    // Sampled late in the high phase; the two sync flops
                    // cost cycles, so HALF_DIV must stay at least three.
                    sclk_d = 1'b0;
                    rx_sh_d = rx_nx;
                    bit_d = bit_q + ONE6;
                    state_d = SFC_ST_LOW;
                    if (word_q < outw_q - ONE6) begin
                        crc_rx_d = crc_step(crc_rx_q, miso_s_q, ansi_q);
                    end
                    if (bit_q == wlen - ONE6) begin
                        bit_d = '0;
                        word_d = nxt_idx;
                        tx_sh_d = {nxt_word, PAD16};
                        if (word_q == '0) begin
                            status_d = rx_val;
                            crc_tx_d = CRC_SEED;
                        end else if (word_q == outw_q - ONE6) begin
                            crc_bad_d = (rx_val[23:8] != crc_rx_q);
                        end else if (rdfr_q) begin
                            rx_we = 1'b1;
                        end else if (word_q == ONE6) begin
                            cha_d = rx_val;
                        end else if (word_q == DATA_OFS) begin
                            chb_d = rx_val;
                        end
                        if (nxt_idx == nw_q) begin
                            state_d = SFC_ST_TRAIL;
                        end
                    end
                end
            end
            SFC_ST_TRAIL: begin
                if (tick) begin
                    cs_n_d = 1'b1;
                    mosi_d = 1'b0;
                    state_d = SFC_ST_GAP;
                end
            end
            SFC_ST_GAP: begin
                // Select stays high a half period so the device
                // sees its interface reset between frames.
                if (tick) begin
                    rsp_valid_d = 1'b1;
                    cmd_ready_d = (op_q != SFC_OP_RESET);
                    state_d = (op_q == SFC_OP_RESET) ? SFC_ST_WAIT
                                                     : SFC_ST_IDLE;
                end
            end
            SFC_ST_WAIT: begin
                if (rdy_s_q) begin
                    cmd_ready_d = 1'b1;
                    state_d = SFC_ST_IDLE;
                end
            end
            default: begin
                state_d = SFC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SFC_ST_WAIT;
            div_q <= '0;        cs_n_q <= 1'b1;     sclk_q <= 1'b0;
            mosi_q <= 1'b0;     tx_sh_q <= '0;      rx_sh_q <= '0;
            crc_tx_q <= CRC_SEED; crc_rx_q <= CRC_SEED;
            bit_q <= '0;        word_q <= '0;       nw_q <= MIN_WORDS;
            outw_q <= MIN_WORDS; rd_m_q <= '0;      op_q <= SFC_OP_NULL;
            addr_q <= '0;       cnt_q <= '0;        w32_q <= 1'b0;
            ansi_q <= 1'b0;     rd_pend_q <= 1'b0;  rdfr_q <= 1'b0;
            status_q <= '0;     cha_q <= '0;        chb_q <= '0;
            crc_bad_q <= 1'b0;  rsp_valid_q <= 1'b0;
            cmd_ready_q <= 1'b0; pcnt_q <= '0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;     cs_n_q <= cs_n_d;   sclk_q <= sclk_d;
            mosi_q <= mosi_d;   tx_sh_q <= tx_sh_d; rx_sh_q <= rx_sh_d;
            crc_tx_q <= crc_tx_d; crc_rx_q <= crc_rx_d;
            bit_q <= bit_d;     word_q <= word_d;   nw_q <= nw_d;
            outw_q <= outw_d;   rd_m_q <= rd_m_d;   op_q <= op_d;
            addr_q <= addr_d;   cnt_q <= cnt_d;     w32_q <= w32_d;
            ansi_q <= ansi_d;   rd_pend_q <= rd_pend_d; rdfr_q <= rdfr_d;
            // Flags pass through raw; each frame's status word replaces the last
            status_q <= status_d;
            cha_q <= cha_d;     chb_q <= chb_d;     crc_bad_q <= crc_bad_d;
            rsp_valid_q <= rsp_valid_d;
            cmd_ready_q <= cmd_ready_d; pcnt_q <= pcnt_d;
        end
    end

    assign cmd_ready      = cmd_ready_q;
    assign rsp_valid      = rsp_valid_q;
    assign rsp_status     = status_q;
    assign rsp_ch_a       = cha_q;
    assign rsp_ch_b       = chb_q;
    assign rsp_crc_bad    = crc_bad_q;
    assign rsp_read_frame = rdfr_q;
    assign chip_select_n  = cs_n_q;
    assign sclk           = sclk_q;
    assign mosi           = mosi_q;
    assign ready_fall     = fall_q;
    assign dev_ready      = rdy_p_q;

    chk_sclk_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        cs_n_q |-> !sclk_q) else $error("clock high outside frame");
    chk_frame_whole_words: assert property (@(posedge ref_clk)
        disable iff (!rstn) $rose(cs_n_q) |->
        pcnt_q == 11'(nw_q) * 11'(wlen))
        else $error("frame not whole words");
    chk_launch_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
        ($changed(mosi_q) && !cs_n_q) |-> $rose(sclk_q))
        else $error("data changed off rising edge");
    chk_rsp_after_frame: assert property (@(posedge ref_clk)
        disable iff (!rstn) $rose(cs_n_q) |-> ##[1:RSP_MAX] rsp_valid_q)
        else $error("no answer after frame");
    chk_min_words: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(cs_n_q) |-> nw_q >= MIN_WORDS)
        else $error("frame shorter than four words");
    chk_null_after_read: assert property (@(posedge ref_clk)
        disable iff (!rstn) (state_q == SFC_ST_LEAD && rdfr_q) |->
        tx_sh_q[31:16] == CMD_NULL)
        else $error("read fetch frame not null");
    chk_cs_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(cs_n_q) |=> cs_n_q [*2])
        else $error("select high too short");
    chk_crc_seed: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(cs_n_q) |-> crc_tx_q == CRC_SEED && crc_rx_q == CRC_SEED)
        else $error("crc not seeded");
    chk_no_order_in_frame: assert property (@(posedge ref_clk)
        disable iff (!rstn) !cs_n_q |-> !cmd_ready_q)
        else $error("ready during frame");
    cov_read_frame: cover property (@(posedge ref_clk) disable iff (!rstn)
        rsp_valid_q && rdfr_q);
    cov_write_frame: cover property (@(posedge ref_clk) disable iff (!rstn)
        rsp_valid_q && op_q == SFC_OP_WRITE);
    cov_crc_bad: cover property (@(posedge ref_clk) disable iff (!rstn)
        rsp_valid_q && crc_bad_q);
    cov_reset_wait: cover property (@(posedge ref_clk) disable iff (!rstn)
        state_q == SFC_ST_WAIT ##1 state_q == SFC_ST_IDLE);
endmodule // sfc_host

// [testbench/sfc_dev_model.sv]
module sfc_dev_model (
    // Serial pins
    input  wire logic chip_select_n,
    input  wire logic sclk,
    input  wire logic mosi,
    output logic      miso,
    output logic      data_ready_n,
    // Bench controls
    input  wire logic word32,
    input  wire logic ansi,
    input  wire logic bad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rx[0:11];
    logic [31:0] tx[0:35];
    logic [15:0] last_cmd, rx_cmd, c;
    logic [7:0]  rd_a;
    logic        crc_err, cmd_ok, data_ok, locked, ign;
    int          wl, oc, ic, ntx, rd_m, n;

    function automatic logic [15:0] crc_w(logic [15:0] s, logic [31:0] w);
        for (int i = 31; i >= 32 - wl; i--) begin
            s = {s[14:0], 1'b0} ^
                ((s[15] ^ w[i]) ? (ansi ? 16'h8005 : 16'h1021) : 16'h0);
        end
        return s;
    endfunction

    initial begin
        last_cmd = 16'h0;
        crc_err = 1'b0;
        rd_m = 0;
        locked = 1'b0;
        miso = 1'b1;
        data_ready_n = 1'b0;
        #500 data_ready_n = 1'b1;
        forever #30000 data_ready_n = 1'b0;
    end

    always @(negedge chip_select_n) begin
        wl = word32 ? 32 : 24;
        ntx = (rd_m > 0) ? rd_m + 2 : 4;
        tx[0] = {last_cmd, ~crc_err, 7'h2a, 8'h00};
        for (int k = 1; k < ntx - 1; k++) begin
            if (rd_m > 0)
                tx[k] = {8'hc0, {2{rd_a + 8'(k - 1)}}, 8'h00};
            else
                tx[k] = {(k == 1) ? 24'h3c5a01 : 24'hc3a502, 8'h00};
        end
        c = 16'hffff;
        for (int k = 0; k < ntx - 1; k++) c = crc_w(c, tx[k]);
        tx[ntx - 1] = {c ^ {15'h0, bad_out}, 16'h0};
        foreach (rx[k]) rx[k] = 32'h0;
        oc = 0;
        ic = 0;
        rd_m = 0;
        crc_err = 1'b0;
        miso = 1'b0;
    end

    always @(posedge sclk) if (!chip_select_n) begin
        miso = (oc < ntx * wl) ? tx[oc / wl][31 - oc % wl] : 1'b0;
        oc++;
    end

    always @(negedge sclk) if (!chip_select_n) begin
        if (ic / wl < 12) rx[ic / wl][31 - ic % wl] = mosi;
        ic++;
    end

    // The first edge, as select leaves unknown at power-up, is no frame
    always @(posedge chip_select_n) if (ic > 0) begin
        miso = ~miso; // No pull on the released line
        rx_cmd = rx[0][31:16];
        cmd_ok = crc_w(16'hffff, rx[0]) == rx[1][31:16];
        n = int'(rx_cmd[2:0]) + 1;
        c = 16'hffff;
        for (int k = 2; k < n + 2; k++) c = crc_w(c, rx[k]);
        data_ok = (rx_cmd[15:13] != 3'b011) || (c == rx[n + 2][31:16]);
        crc_err = !(cmd_ok && data_ok);
        ign = locked && rx_cmd != 16'h0 && rx_cmd != 16'h0655 &&
              rx_cmd[15:13] != 3'b101;
        last_cmd = (crc_err || ign) ? 16'h0 : rx_cmd;
        if (!crc_err && !ign && rx_cmd == 16'h0555) locked = 1'b1;
        if (!crc_err && rx_cmd == 16'h0655) locked = 1'b0;
        if (!crc_err && rx_cmd[15:13] == 3'b101) begin
            rd_a = rx_cmd[12:5];
            rd_m = int'(rx_cmd[4:0]) + 1;
        end
        data_ready_n = 1'b1;
        if (!crc_err && !ign && rx_cmd == 16'h0011) begin
            locked = 1'b0;
            data_ready_n = 1'b0;
            #300 data_ready_n = 1'b1;
        end
    end
endmodule // sfc_dev_model

// [testbench/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfc_pkg::*;
    logic        ref_clk, rstn, cmd_valid, cfg_word32, cfg_crc_ansi, wr_en;
    logic        bad_out, cmd_ready, rsp_valid, rsp_crc_bad, rsp_read_frame;
    logic        chip_select_n, sclk, mosi, miso, data_ready_n;
    logic        ready_fall, dev_ready;
    sfc_op_t     cmd_op;
    logic [7:0]  cmd_addr;
    logic [4:0]  cmd_count, rd_idx;
    logic [2:0]  wr_idx;
    logic [15:0] wr_data;
    logic [23:0] rsp_status, rsp_ch_a, rsp_ch_b, rd_word;
    int          miscompares = 0;
    int          tests_run = 0;

    sfc_host DUT (.ref_clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
        .cmd_count, .cfg_word32, .cfg_crc_ansi, .wr_en, .wr_idx, .wr_data,
        .rsp_valid, .rsp_status, .rsp_ch_a, .rsp_ch_b, .rsp_crc_bad,
        .rsp_read_frame, .rd_idx, .rd_word, .chip_select_n, .sclk, .mosi,
        .miso, .data_ready_n, .ready_fall, .dev_ready);
    sfc_dev_model DEV (.chip_select_n, .sclk, .mosi, .miso, .data_ready_n,
        .word32(cfg_word32), .ansi(cfg_crc_ansi), .bad_out);

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string what);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic order(input sfc_op_t op, input logic [7:0] a,
                         input logic [4:0] n);
        int i;
        for (i = 0; cmd_ready !== 1'b1 && i < 5000; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(i < 5000, 1, "not ready");
        cmd_op = op;
        cmd_addr = a;
        cmd_count = n;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #1 cmd_valid = 1'b0;
        for (i = 0; rsp_valid !== 1'b1 && i < 12000; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(i < 12000, 1, "no answer");
    endtask

    task automatic t_codes;
        // The second reset arrives while locked and must be answered as null
        sfc_op_t ops[5] = '{SFC_OP_RESET, SFC_OP_LOCK, SFC_OP_RESET,
                            SFC_OP_UNLOCK, SFC_OP_NULL};
        logic [15:0] cd[5] = '{16'h0011, 16'h0555, 16'h0011, 16'h0655,
                               16'h0000};
        logic [15:0] rs[5] = '{16'h0000, 16'h0011, 16'h0555, 16'h0000,
                               16'h0655};
        cfg_crc_ansi = 1'b0;
        order(SFC_OP_NULL, 8'h0, 5'h0);
        chk(DEV.cmd_ok, 1, "ccitt crc");
        chk(rsp_status, 24'h0000aa, "status");
        chk(rsp_ch_b, 24'hc3a502, "ch b");
        cfg_word32 = 1'b1;
        cfg_crc_ansi = 1'b1;
        foreach (ops[k]) begin
            order(ops[k], 8'h0, 5'h0);
            chk(DEV.rx_cmd, cd[k], "code");
            chk(DEV.cmd_ok, 1, "ansi crc");
            chk(rsp_ch_a, 24'h3c5a01, "ch a wide");
            if (k > 0) chk(rsp_status[23:8], rs[k], "response");
        end
        $display("codes done");
    endtask

    task automatic t_write;
        cfg_crc_ansi = 1'b0;
        @(posedge ref_clk);
        #1 wr_en = 1'b1;
        wr_idx = 3'h0;
        wr_data = 16'hbeef;
        @(posedge ref_clk);
        #1 wr_idx = 3'h1;
        wr_data = 16'h1234;
        @(posedge ref_clk);
        #1 wr_en = 1'b0;
        order(SFC_OP_WRITE, 8'h41, 5'h1);
        chk(DEV.rx_cmd, {3'b011, 8'h41, 2'b00, 3'h1}, "write code");
        chk(DEV.data_ok, 1, "data crc");
        chk(DEV.rx[2], 32'hbeef0000, "data 0");
        chk(DEV.rx[3], 32'h12340000, "data 1");
        $display("write done");
    endtask

    task automatic t_read;
        cfg_word32 = 1'b0;
        order(SFC_OP_READ, 8'h10, 5'h2);
        chk(DEV.rx_cmd, {3'b101, 8'h10, 5'h2}, "read code");
        order(SFC_OP_NULL, 8'h0, 5'h0);
        chk(rsp_read_frame, 1, "read frame");
        chk(rsp_crc_bad, 0, "read crc");
        for (int k = 0; k < 3; k++) begin
            rd_idx = 5'(k);
            @(posedge ref_clk);
            #1 chk(rd_word, {8'hc0, {2{8'h10 + 8'(k)}}}, "read word");
        end
        $display("read done");
    endtask

    task automatic t_faults;
        int i;
        bad_out = 1'b1;
        order(SFC_OP_NULL, 8'h0, 5'h0);
        chk(rsp_crc_bad, 1, "bad crc");
        bad_out = 1'b0;
        for (i = 0; ready_fall !== 1'b1 && i < 5000; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(i < 5000, 1, "ready fall");
        order(SFC_OP_NULL, 8'h0, 5'h0);
        chk(rsp_crc_bad, 0, "good crc");
        chk(dev_ready, 1, "ready high");
        $display("faults done");
    endtask

    task automatic final_report;
        $display("tests %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        {rstn, cmd_valid, cfg_word32, cfg_crc_ansi, wr_en, bad_out} = 6'h0;
        {cmd_addr, cmd_count, rd_idx, wr_idx, wr_data} = 37'h0;
        cmd_op = SFC_OP_NULL;
        repeat (6) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1 chk(cmd_ready, 0, "held off");
        t_codes();
        t_write();
        t_read();
        t_faults();
        final_report();
    end

    initial begin
        #700000;
        miscompares++;
        final_report();
    end
endmodule // testbench
